// >>> verilog/hrs_cmd_regs.vh
// offsets, opcodes, reset values and counts of the host command block
`ifndef HRS_CMD_REGS_VH
`define HRS_CMD_REGS_VH

`define HRS_OP_WRITE_REG 8'h6A
`define HRS_OP_READ_REG 8'h6B
`define HRS_OP_TEMP 8'h6C
`define HRS_OP_CAL_READ 8'h6D
`define HRS_OP_CAL_WRITE 8'h6E
`define HRS_OP_STATUS 8'hFE

`define HRS_ADDR_TRIG_MODE 8'h2C
`define HRS_ADDR_RSVD_A 8'h30
`define HRS_ADDR_STROBE_RISE 8'h38
`define HRS_ADDR_STROBE_FALL 8'h3C
`define HRS_ADDR_LAMP 8'h40
`define HRS_ADDR_PIN_FUNC 8'h48
`define HRS_ADDR_PIN_DIR 8'h50
`define HRS_ADDR_PIN_VALUE 8'h54
`define HRS_ADDR_RSVD_B 8'h58
`define HRS_ADDR_RSVD_C 8'h5C
`define HRS_ADDR_OFS_VALUE 8'h74
`define HRS_ADDR_OFS_CTRL 8'h78
`define HRS_ADDR_SIGNATURE 8'h7C
`define HRS_ADDR_SAT_CEIL 8'h80
`define HRS_ADDR_CONV_DELAY 8'hD4
`define HRS_ADDR_CONV_WIDTH 8'hD8

`define HRS_RST_TRIG_MODE 16'h0000
`define HRS_RST_STROBE_RISE 16'h0001
`define HRS_RST_STROBE_FALL 16'h0005
`define HRS_RST_OFS_VALUE 16'h0000
`define HRS_RST_OFS_CTRL 16'h0000
`define HRS_RST_SAT_CEIL 16'h55F0
`define HRS_RST_CONV_DELAY 16'h002E
`define HRS_RST_CONV_WIDTH 16'h0010

`define HRS_OFS_AUTONULL_BIT 0
`define HRS_OFS_AUTONULL_SAT_BIT 1

`define HRS_TEMP_OK 8'h08
`define HRS_TEMP_FAIL 8'h00
`define HRS_SPEED_HIGH 8'h80
`define HRS_SPEED_FULL 8'h00

`define HRS_CAL_LEN 6'h3C
`define HRS_STATUS_LEN 6'h10
`define HRS_REG_REPLY_LEN 6'h03

`endif

// >>> verilog/hrs_cal_mem.v
// calibration byte store with registered read data
`timescale 1ns/1ns
module hrs_cal_mem #(
   parameter AW = 10,
   parameter DW = 8
) (
   input wire clk,
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [DW-1:0] wdata,
   input wire [AW-1:0] raddr,
   output reg [DW-1:0] rdata_q
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // no reset: contents model nonvolatile storage
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_q <= mem[raddr];
   end
endmodule

// >>> verilog/hrs_pin_bank.v
// general purpose pin bank: per-pin function, direction and value
`timescale 1ns/1ns
module hrs_pin_bank #(
   parameter NPIN = 10
) (
   input wire clk,
   input wire rst_n,
   input wire [NPIN-1:0] func_sel,
   input wire [NPIN-1:0] dir_out,
   input wire [NPIN-1:0] value,
   input wire [NPIN-1:0] alt_out,
   input wire [NPIN-1:0] alt_oe,
   input wire [NPIN-1:0] pin_i,
   output reg [NPIN-1:0] pin_o,
   output reg [NPIN-1:0] pin_oe_n,
   output reg [NPIN-1:0] pin_state_q
);
   genvar i;
   generate
      for (i = 0; i < NPIN; i = i + 1) begin : g_pin
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               pin_o[i] <= 1'b0;
               pin_oe_n[i] <= 1'b1;
               pin_state_q[i] <= 1'b0;
            end else begin
               if (func_sel[i]) begin
                  pin_o[i] <= alt_out[i];
                  pin_oe_n[i] <= ~alt_oe[i];
               end else begin
                  pin_o[i] <= value[i];
                  pin_oe_n[i] <= ~dir_out[i];
               end
               pin_state_q[i] <= pin_i[i];
            end
         end
      end
   endgenerate
endmodule

// >>> verilog/hrs_cmd_top.v
// host command interpreter: register map, readback, temperature, cal, status
// Operation
// - trigger mode register selects how acquisition starts.
// - offset control bit 0 enables auto-nulling, bit 1 saturation handling.
// - read-register returns address, value high byte, value low byte.
// - temperature command returns result byte, value low then high byte.
// - result byte 0x08 means success; other values mean invalid reading.
// - calibration read returns 60 bytes from consecutive addresses.
// - status query returns a 16-byte status packet.
// - bytes 0-1 pixel count; bytes 2-5 integration time, all low first.
// - status byte 9 gives packets per spectrum request.
// - status byte 11 gives packets loaded into endpoint memory.
// - status byte 10 is 0 powered down, 1 powered up.
// - status byte 14 is 0 full speed, 0x80 high speed.
// - trigger mode register also follows the dedicated trigger command path.
`timescale 1ns/1ns
`include "hrs_cmd_regs.vh"
module hrs_cmd_top #(
   parameter NPIN = 10,
   parameter CAL_AW = 10,
   // arbitrary value
   parameter [15:0] SIGNATURE = 16'hA5C3
) (
   input wire clk,
   input wire rst_n,
   input wire [7:0] out_data,
   input wire out_valid,
   output reg out_ready_q,
   output reg [7:0] in_data_q,
   output reg in_valid_q,
   input wire in_ready,
   input wire trig_cmd_valid,
   input wire [15:0] trig_cmd_mode,
   input wire [15:0] temp_value,
   input wire temp_ok,
   input wire [15:0] pixel_count,
   input wire [31:0] integ_time_us,
   input wire [7:0] acq_status,
   input wire [7:0] packets_per_spectrum,
   input wire powered_up,
   input wire [7:0] packets_loaded,
   input wire high_speed,
   input wire [NPIN-1:0] alt_out,
   input wire [NPIN-1:0] alt_oe,
   input wire [NPIN-1:0] pin_i,
   output wire [NPIN-1:0] pin_o,
   output wire [NPIN-1:0] pin_oe_n,
   output reg [15:0] trig_mode_q,
   output reg [15:0] strobe_rise_q,
   output reg [15:0] strobe_fall_q,
   output reg lamp_en_q,
   output reg [15:0] ofs_value_q,
   output reg [15:0] ofs_ctrl_q,
   output reg [15:0] sat_ceil_q,
   output reg [15:0] conv_delay_q,
   output reg [15:0] conv_width_q
);
   localparam [2:0] ST_OP = 3'h0;
   localparam [2:0] ST_ARG = 3'h1;
   localparam [2:0] ST_CALW = 3'h2;
   localparam [2:0] ST_FETCH = 3'h3;
   localparam [2:0] ST_SEND = 3'h4;

   localparam [3:0] R_NONE = 4'h0;
   localparam [3:0] R_TRIG = 4'h1;
   localparam [3:0] R_RISE = 4'h2;
   localparam [3:0] R_FALL = 4'h3;
   localparam [3:0] R_LAMP = 4'h4;
   localparam [3:0] R_FUNC = 4'h5;
   localparam [3:0] R_DIR = 4'h6;
   localparam [3:0] R_VAL = 4'h7;
   localparam [3:0] R_OFSV = 4'h8;
   localparam [3:0] R_OFSC = 4'h9;
   localparam [3:0] R_SIG = 4'hA;
   localparam [3:0] R_SAT = 4'hB;
   localparam [3:0] R_CDLY = 4'hC;
   localparam [3:0] R_CWID = 4'hD;

   // register address decode, shared by write and readback
   function [3:0] reg_sel;
      input [7:0] a;
      begin
         case (a)
            `HRS_ADDR_TRIG_MODE: reg_sel = R_TRIG;
            `HRS_ADDR_STROBE_RISE: reg_sel = R_RISE;
            `HRS_ADDR_STROBE_FALL: reg_sel = R_FALL;
            `HRS_ADDR_LAMP: reg_sel = R_LAMP;
            `HRS_ADDR_PIN_FUNC: reg_sel = R_FUNC;
            `HRS_ADDR_PIN_DIR: reg_sel = R_DIR;
            `HRS_ADDR_PIN_VALUE: reg_sel = R_VAL;
            `HRS_ADDR_OFS_VALUE: reg_sel = R_OFSV;
            `HRS_ADDR_OFS_CTRL: reg_sel = R_OFSC;
            `HRS_ADDR_SIGNATURE: reg_sel = R_SIG;
            `HRS_ADDR_SAT_CEIL: reg_sel = R_SAT;
            `HRS_ADDR_CONV_DELAY: reg_sel = R_CDLY;
            `HRS_ADDR_CONV_WIDTH: reg_sel = R_CWID;
            default: reg_sel = R_NONE;
         endcase
      end
   endfunction

   // argument bytes that follow each opcode; 0 for single-byte commands
   function [1:0] arg_count;
      input [7:0] op;
      begin
         case (op)
            `HRS_OP_WRITE_REG: arg_count = 2'd3;
            `HRS_OP_READ_REG: arg_count = 2'd1;
            `HRS_OP_CAL_READ: arg_count = 2'd2;
            `HRS_OP_CAL_WRITE: arg_count = 2'd2;
            default: arg_count = 2'd0;
         endcase
      end
   endfunction

   function known_op;
      input [7:0] op;
      begin
         case (op)
            `HRS_OP_WRITE_REG, `HRS_OP_READ_REG, `HRS_OP_TEMP,
            `HRS_OP_CAL_READ, `HRS_OP_CAL_WRITE, `HRS_OP_STATUS:
               known_op = 1'b1;
            default: known_op = 1'b0;
         endcase
      end
   endfunction

   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [7:0] op_q;
   reg [1:0] arg_idx_q;
   reg [7:0] a0_q;
   reg [7:0] a1_q;
   reg [15:0] base_q;
   reg [5:0] idx_q;
   reg [15:0] temp_q;
   reg temp_ok_q;
   reg [NPIN-1:0] func_q;
   reg [NPIN-1:0] dir_q;
   reg [NPIN-1:0] val_q;
   reg [15:0] rd_val;
   reg [7:0] reply_byte;
   reg [5:0] reply_len;
   wire [NPIN-1:0] pin_state;
   wire [7:0] cal_rdata;
   wire take;
   wire last_arg;
   wire reg_we;
   wire cal_we;
   wire [15:0] cal_addr;
   wire [15:0] wr_word;

   assign take = out_valid & out_ready_q;
   assign last_arg = (arg_idx_q == arg_count(op_q) - 2'd1);
   // write completes on the data high byte
   assign reg_we = (state_q == ST_ARG) & take & last_arg &
                   (op_q == `HRS_OP_WRITE_REG);
   assign cal_we = (state_q == ST_CALW) & take;
   assign cal_addr = base_q + {10'h000, idx_q};
   // data low byte was held, high byte is on the bus now
   assign wr_word = {out_data, a1_q};

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_OP: begin
            if (take && known_op(out_data)) begin
               if (arg_count(out_data) != 2'd0) begin
                  state_d = ST_ARG;
               end else begin
                  state_d = ST_SEND;
               end
            end
         end
         ST_ARG: begin
            if (take && last_arg) begin
               case (op_q)
                  `HRS_OP_WRITE_REG: state_d = ST_OP;
                  `HRS_OP_CAL_READ: state_d = ST_FETCH;
                  `HRS_OP_CAL_WRITE: state_d = ST_CALW;
                  default: state_d = ST_SEND;
               endcase
            end
         end
         ST_CALW: begin
            if (take && idx_q == `HRS_CAL_LEN - 6'd1) begin
               state_d = ST_OP;
            end
         end
         ST_FETCH: state_d = ST_SEND;
         ST_SEND: begin
            if (in_valid_q && in_ready) begin
               if (idx_q == reply_len - 6'd1) begin
                  state_d = ST_OP;
               end else if (op_q == `HRS_OP_CAL_READ) begin
                  state_d = ST_FETCH;
               end
            end
         end
         default: state_d = ST_OP;
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_OP;
         out_ready_q <= 1'b0;
         in_valid_q <= 1'b0;
         in_data_q <= 8'h00;
         op_q <= 8'h00;
         arg_idx_q <= 2'd0;
         a0_q <= 8'h00;
         a1_q <= 8'h00;
         base_q <= 16'h0000;
         idx_q <= 6'd0;
         temp_q <= 16'h0000;
         temp_ok_q <= 1'b0;
      end else begin
         state_q <= state_d;
         // only take bytes while no reply is pending
         out_ready_q <= (state_d == ST_OP) | (state_d == ST_ARG) |
                        (state_d == ST_CALW);
         case (state_q)
            ST_OP: begin
               if (take) begin
                  op_q <= out_data;
                  arg_idx_q <= 2'd0;
                  idx_q <= 6'd0;
                  temp_q <= temp_value;
                  temp_ok_q <= temp_ok;
               end
            end
            ST_ARG: begin
               if (take) begin
                  arg_idx_q <= arg_idx_q + 2'd1;
                  if (arg_idx_q == 2'd0) begin
                     a0_q <= out_data;
                  end else if (arg_idx_q == 2'd1) begin
                     a1_q <= out_data;
                  end
                  // address low byte then high byte
                  if (last_arg) begin
                     base_q <= {out_data, a0_q};
                  end
               end
            end
            ST_CALW: begin
               if (take) begin
                  idx_q <= idx_q + 6'd1;
               end
            end
            ST_SEND: begin
               if (!in_valid_q) begin
                  in_valid_q <= 1'b1;
                  in_data_q <= reply_byte;
               end else if (in_ready) begin
                  in_valid_q <= 1'b0;
                  idx_q <= idx_q + 6'd1;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trig_mode_q <= `HRS_RST_TRIG_MODE;
         strobe_rise_q <= `HRS_RST_STROBE_RISE;
         strobe_fall_q <= `HRS_RST_STROBE_FALL;
         lamp_en_q <= 1'b0;
         func_q <= {NPIN{1'b0}};
         dir_q <= {NPIN{1'b0}};
         val_q <= {NPIN{1'b0}};
         ofs_value_q <= `HRS_RST_OFS_VALUE;
         ofs_ctrl_q <= `HRS_RST_OFS_CTRL;
         sat_ceil_q <= `HRS_RST_SAT_CEIL;
         conv_delay_q <= `HRS_RST_CONV_DELAY;
         conv_width_q <= `HRS_RST_CONV_WIDTH;
      end else begin
         if (reg_we) begin
            // unmapped addresses fall to the default
            case (reg_sel(a0_q))
               R_TRIG: trig_mode_q <= {out_data, a1_q};
               R_RISE: strobe_rise_q <= {out_data, a1_q};
               R_FALL: strobe_fall_q <= {out_data, a1_q};
               R_LAMP: lamp_en_q <= a1_q[0];
               R_FUNC: func_q <= wr_word[NPIN-1:0];
               R_DIR: dir_q <= wr_word[NPIN-1:0];
               R_VAL: val_q <= wr_word[NPIN-1:0];
               R_OFSV: ofs_value_q <= {out_data, a1_q};
               R_OFSC: ofs_ctrl_q <= {out_data, a1_q};
               R_SAT: sat_ceil_q <= {out_data, a1_q};
               R_CDLY: conv_delay_q <= {out_data, a1_q};
               R_CWID: conv_width_q <= {out_data, a1_q};
               default: begin
               end
            endcase
         end
         // dedicated command path wins a tie
         if (trig_cmd_valid) begin
            trig_mode_q <= trig_cmd_mode;
         end
      end
   end

   always @* begin
      rd_val = 16'h0000;
      case (reg_sel(a0_q))
         R_TRIG: rd_val = trig_mode_q;
         R_RISE: rd_val = strobe_rise_q;
         R_FALL: rd_val = strobe_fall_q;
         R_LAMP: rd_val = {15'h0000, lamp_en_q};
         R_FUNC: rd_val[NPIN-1:0] = func_q;
         R_DIR: rd_val[NPIN-1:0] = dir_q;
         R_VAL: rd_val[NPIN-1:0] = pin_state;
         R_OFSV: rd_val = ofs_value_q;
         R_OFSC: rd_val = ofs_ctrl_q;
         R_SIG: rd_val = SIGNATURE;
         R_SAT: rd_val = sat_ceil_q;
         R_CDLY: rd_val = conv_delay_q;
         R_CWID: rd_val = conv_width_q;
         default: rd_val = 16'h0000;
      endcase
   end

   always @* begin
      reply_byte = 8'h00;
      reply_len = `HRS_REG_REPLY_LEN;
      case (op_q)
         `HRS_OP_READ_REG: begin
            case (idx_q)
               6'd0: reply_byte = a0_q;
               6'd1: reply_byte = rd_val[15:8];
               default: reply_byte = rd_val[7:0];
            endcase
         end
         `HRS_OP_TEMP: begin
            case (idx_q)
               6'd0: reply_byte = temp_ok_q ? `HRS_TEMP_OK : `HRS_TEMP_FAIL;
               6'd1: reply_byte = temp_q[7:0];
               default: reply_byte = temp_q[15:8];
            endcase
         end
         `HRS_OP_CAL_READ: begin
            reply_len = `HRS_CAL_LEN;
            reply_byte = cal_rdata;
         end
         `HRS_OP_STATUS: begin
            reply_len = `HRS_STATUS_LEN;
            case (idx_q)
               6'd0: reply_byte = pixel_count[7:0];
               6'd1: reply_byte = pixel_count[15:8];
               6'd2: reply_byte = integ_time_us[7:0];
               6'd3: reply_byte = integ_time_us[15:8];
               6'd4: reply_byte = integ_time_us[23:16];
               6'd5: reply_byte = integ_time_us[31:24];
               6'd6: reply_byte = {7'h00, lamp_en_q};
               6'd7: reply_byte = trig_mode_q[7:0];
               6'd8: reply_byte = acq_status;
               6'd9: reply_byte = packets_per_spectrum;
               6'd10: reply_byte = {7'h00, powered_up};
               6'd11: reply_byte = packets_loaded;
               6'd14: reply_byte = high_speed ? `HRS_SPEED_HIGH :
                                                `HRS_SPEED_FULL;
               default: reply_byte = 8'h00;
            endcase
         end
         default: reply_byte = 8'h00;
      endcase
   end

   // address wraps within the fitted store size
   hrs_cal_mem #(
      .AW(CAL_AW),
      .DW(8)
   ) u_cal (
      .clk(clk),
      .we(cal_we),
      .waddr(cal_addr[CAL_AW-1:0]),
      .wdata(out_data),
      .raddr(cal_addr[CAL_AW-1:0]),
      .rdata_q(cal_rdata)
   );

   hrs_pin_bank #(
      .NPIN(NPIN)
   ) u_pins (
      .clk(clk),
      .rst_n(rst_n),
      .func_sel(func_q),
      .dir_out(dir_q),
      .value(val_q),
      .alt_out(alt_out),
      .alt_oe(alt_oe),
      .pin_i(pin_i),
      .pin_o(pin_o),
      .pin_oe_n(pin_oe_n),
      .pin_state_q(pin_state)
   );
endmodule

// >>> bench/hrs_cmd_checker.sv
// port-level assertions for the host command block
`timescale 1ns/1ns
`include "hrs_cmd_regs.vh"
module hrs_cmd_checker (
   input wire clk,
   input wire rst_n,
   input wire [7:0] out_data,
   input wire out_valid,
   input wire out_ready_q,
   input wire [7:0] in_data_q,
   input wire in_valid_q,
   input wire in_ready,
   input wire trig_cmd_valid,
   input wire [15:0] trig_cmd_mode,
   input wire temp_ok,
   input wire [15:0] pixel_count,
   input wire [15:0] trig_mode_q
);
   wire take = out_valid && out_ready_q;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_rd_cmd;
      take && out_data == `HRS_OP_READ_REG ##1 take;
   endsequence
   // only back-to-back writes are seen; a stalled host is not checked
   sequence s_wr_trig;
      take && out_data == `HRS_OP_WRITE_REG ##1
      take && out_data == `HRS_ADDR_TRIG_MODE ##1 take ##1 take;
   endsequence
   a_trig_follow: assert property (
      trig_cmd_valid |=> trig_mode_q == $past(trig_cmd_mode))
      else $error("trigger mode missed the command path");
   a_write_lands: assert property (
      s_wr_trig |=> trig_mode_q == {$past(out_data), $past(out_data, 2)})
      else $error("trigger mode write not applied");
   a_read_echo: assert property (
      s_rd_cmd |=> ##1 in_valid_q && in_data_q == $past(out_data, 2))
      else $error("readback does not start with address");
   a_temp_code: assert property (
      take && out_data == `HRS_OP_TEMP |=> ##1 in_valid_q &&
      in_data_q == ($past(temp_ok, 2) ? `HRS_TEMP_OK : `HRS_TEMP_FAIL))
      else $error("temperature result code wrong");
   a_status_first: assert property (
      take && out_data == `HRS_OP_STATUS |=> ##1 in_valid_q &&
      in_data_q == $past(pixel_count[7:0]))
      else $error("status byte 0 wrong");
   a_reply_holds: assert property (
      in_valid_q && !in_ready |=> in_valid_q && $stable(in_data_q))
      else $error("reply byte dropped before acceptance");
   a_reply_gap: assert property (
      in_valid_q && in_ready |=> !in_valid_q)
      else $error("reply valid not lowered after acceptance");
   a_busy_refuse: assert property (
      in_valid_q |-> !out_ready_q)
      else $error("command byte accepted during reply");
endmodule

// >>> bench/hrs_host_model.sv
// host side model: feeds command bytes, drains reply bytes
`timescale 1ns/1ns
`include "hrs_cmd_regs.vh"
module hrs_host_model #(
   parameter GAP = 2000
) (
   input wire clk,
   output logic [7:0] out_data,
   output logic out_valid,
   input wire out_ready_q,
   input wire [7:0] in_data_q,
   input wire in_valid_q,
   output logic in_ready
);
   int stall = 0;
   initial begin
      out_data = 8'hFF;
      out_valid = 1'b0;
      in_ready = 1'b0;
   end
   // call at a falling edge; bytes go back to back, released after last
   task automatic send_q(input logic [7:0] q[$]);
      int n;
      foreach (q[i]) begin
         out_data = q[i];
         out_valid = 1'b1;
         n = 0;
         while (out_ready_q !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
         end
         @(posedge clk);
         @(negedge clk);
      end
      out_valid = 1'b0;
      out_data = ~q[q.size()-1];
   endtask
   // a lost byte comes back as unknown so the compare fails
   task automatic recv_n(input int cnt, output logic [7:0] q[$]);
      int n;
      q = {};
      for (int k = 0; k < cnt; k++) begin
         if (stall > 0) begin
            in_ready = 1'b0;
            repeat (stall) @(negedge clk);
         end
         in_ready = 1'b1;
         n = 0;
         while (in_valid_q !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
         end
         q.push_back((n < 300) ? in_data_q : 8'hXX);
         @(posedge clk);
         @(negedge clk);
      end
      in_ready = 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      send_q({`HRS_OP_WRITE_REG, a, v[7:0], v[15:8]});
      repeat (GAP) @(negedge clk);
   endtask
endmodule

// >>> bench/tb.sv
// self-checking bench for the host command block
`timescale 1ns/1ns
`include "hrs_cmd_regs.vh"
module tb;
   logic clk, rst_n, trig_cmd_valid, temp_ok, powered_up, high_speed;
   logic [15:0] trig_cmd_mode, temp_value, pixel_count;
   logic [31:0] integ_time_us;
   logic [7:0] acq_status, packets_per_spectrum, packets_loaded;
   logic [9:0] alt_out, alt_oe, ext_pins;
   wire [9:0] pin_i, pin_o, pin_oe_n;
   wire [7:0] out_data, in_data_q;
   wire out_valid, out_ready_q, in_valid_q, in_ready, lamp_en_q;
   wire [15:0] trig_mode_q, strobe_rise_q, strobe_fall_q, ofs_value_q;
   wire [15:0] ofs_ctrl_q, sat_ceil_q, conv_delay_q, conv_width_q;
   int bad_count = 0;
   int checks = 0;
   logic [7:0] q[$];
   logic [7:0] cq[$];
   logic [7:0] ra[16] = '{8'h2C, 8'h38, 8'h3C, 8'h40, 8'h48, 8'h50, 8'h54,
      8'h74, 8'h78, 8'h7C, 8'h80, 8'hD4, 8'hD8, 8'h30, 8'h58, 8'h5C};
   logic [15:0] rv[16] = '{16'h0000, 16'h0001, 16'h0005, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hA5C3,
      16'h55F0, 16'h002E, 16'h0010, 16'h0000, 16'h0000, 16'h0000};
   logic [7:0] wa[7] = '{8'h38, 8'h3C, 8'h74, 8'h78, 8'h80, 8'hD4, 8'hD8};
   logic [7:0] xa[4] = '{8'h30, 8'h58, 8'h5C, 8'h44};
   logic [7:0] sx[16];
   // undriven pins float; the far side holds them at ext_pins
   assign pin_i = (~pin_oe_n & pin_o) | (pin_oe_n & ext_pins);
   always #25 clk = ~clk;
   hrs_cmd_top #(.CAL_AW(6)) u_dut (.clk(clk), .rst_n(rst_n),
      .out_data(out_data), .out_valid(out_valid), .out_ready_q(out_ready_q),
      .in_data_q(in_data_q), .in_valid_q(in_valid_q), .in_ready(in_ready),
      .trig_cmd_valid(trig_cmd_valid), .trig_cmd_mode(trig_cmd_mode),
      .temp_value(temp_value), .temp_ok(temp_ok), .pixel_count(pixel_count),
      .integ_time_us(integ_time_us), .acq_status(acq_status),
      .packets_per_spectrum(packets_per_spectrum), .powered_up(powered_up),
      .packets_loaded(packets_loaded), .high_speed(high_speed),
      .alt_out(alt_out), .alt_oe(alt_oe), .pin_i(pin_i), .pin_o(pin_o),
      .pin_oe_n(pin_oe_n), .trig_mode_q(trig_mode_q),
      .strobe_rise_q(strobe_rise_q), .strobe_fall_q(strobe_fall_q),
      .lamp_en_q(lamp_en_q), .ofs_value_q(ofs_value_q),
      .ofs_ctrl_q(ofs_ctrl_q), .sat_ceil_q(sat_ceil_q),
      .conv_delay_q(conv_delay_q), .conv_width_q(conv_width_q));
   hrs_host_model u_host (.clk(clk), .out_data(out_data),
      .out_valid(out_valid), .out_ready_q(out_ready_q),
      .in_data_q(in_data_q), .in_valid_q(in_valid_q), .in_ready(in_ready));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      logic [7:0] r[$];
      u_host.send_q({`HRS_OP_READ_REG, a});
      u_host.recv_n(3, r);
      chk(r[0], a);
      chk({r[1], r[2]}, exp);
   endtask
   function automatic logic [15:0] port_of(input logic [7:0] a);
      case (a)
         8'h38: port_of = strobe_rise_q;
         8'h3C: port_of = strobe_fall_q;
         8'h74: port_of = ofs_value_q;
         8'h78: port_of = ofs_ctrl_q;
         8'h80: port_of = sat_ceil_q;
         8'hD4: port_of = conv_delay_q;
         default: port_of = conv_width_q;
      endcase
   endfunction
   task results;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (95000) @(posedge clk);
      bad_count++;
      results;
   end
   initial begin
      clk = 0; rst_n = 0; trig_cmd_valid = 0; trig_cmd_mode = 16'h0000;
      temp_value = 16'hFF38; temp_ok = 1; pixel_count = 16'h0EA4;
      integ_time_us = 32'h0001_86A0; acq_status = 8'h03;
      packets_per_spectrum = 8'h0F; powered_up = 0; packets_loaded = 8'h05;
      high_speed = 0; alt_out = 10'h000; alt_oe = 10'h001; ext_pins = 10'h0AA;
      repeat (10) @(posedge clk);
      @(negedge clk) rst_n = 1;
      @(negedge clk);
      for (int i = 0; i < 16; i++)
         rd(ra[i], (i == 6) ? 16'h00AA : rv[i]);
      for (int m = 0; m < 5; m++) begin
         u_host.wr(8'h2C, m[15:0]);
         chk(trig_mode_q, m[15:0]);
      end
      trig_cmd_mode = 16'h0003;
      trig_cmd_valid = 1;
      @(negedge clk) trig_cmd_valid = 0;
      rd(8'h2C, 16'h0003);
      foreach (wa[i]) begin
         u_host.wr(wa[i], {wa[i], ~wa[i]});
         chk(port_of(wa[i]), {wa[i], ~wa[i]});
         rd(wa[i], {wa[i], ~wa[i]});
      end
      chk(ofs_ctrl_q[1:0], 16'h0003);
      u_host.wr(8'h40, 16'h0001);
      chk(lamp_en_q, 16'h0001);
      foreach (xa[i]) begin
         u_host.wr(xa[i], 16'h1357);
         rd(xa[i], 16'h0000);
      end
      u_host.wr(8'h50, 16'h0155);
      u_host.wr(8'h54, 16'h03FF);
      chk(pin_oe_n, 16'h02AA);
      rd(8'h54, 16'h01FF);
      u_host.wr(8'h48, 16'h0001);
      chk({pin_oe_n[0], pin_o[0]}, 16'h0000);
      rd(8'h48, 16'h0001);
      for (int k = 1; k >= 0; k--) begin
         temp_ok = k[0];
         u_host.send_q({`HRS_OP_TEMP});
         u_host.recv_n(3, q);
         chk(q[0], k ? `HRS_TEMP_OK : `HRS_TEMP_FAIL);
         if (k) chk({q[2], q[1]}, 16'hFF38);
      end
      cq = {`HRS_OP_CAL_WRITE, 8'h05, 8'h00};
      for (int i = 0; i < 60; i++) cq.push_back(8'h80 + i[7:0]);
      u_host.send_q(cq);
      u_host.stall = 2;
      // valid must not drop and rise again in one step
      @(negedge clk);
      u_host.send_q({`HRS_OP_CAL_READ, 8'h05, 8'h00});
      u_host.recv_n(60, q);
      foreach (q[i]) chk(q[i], 8'h80 + i[7:0]);
      repeat (6) @(negedge clk);
      chk(in_valid_q, 16'h0000);
      for (int h = 0; h < 2; h++) begin
         powered_up = h[0];
         high_speed = h[0];
         sx = '{8'hA4, 8'h0E, 8'hA0, 8'h86, 8'h01, 8'h00, 8'h01, 8'h03,
            8'h03, 8'h0F, {7'h00, h[0]}, 8'h05, 8'h00, 8'h00,
            h ? `HRS_SPEED_HIGH : `HRS_SPEED_FULL, 8'h00};
         @(negedge clk);
         u_host.send_q({`HRS_OP_STATUS});
         u_host.recv_n(16, q);
         foreach (sx[i]) chk(q[i], sx[i]);
      end
      // leave the sensitive trigger mode as it came out of reset
      u_host.wr(8'h2C, `HRS_RST_TRIG_MODE);
      chk(trig_mode_q, `HRS_RST_TRIG_MODE);
      results;
   end
endmodule
bind hrs_cmd_top hrs_cmd_checker u_chk (.clk(clk), .rst_n(rst_n),
   .out_data(out_data), .out_valid(out_valid), .out_ready_q(out_ready_q),
   .in_data_q(in_data_q), .in_valid_q(in_valid_q), .in_ready(in_ready),
   .trig_cmd_valid(trig_cmd_valid), .trig_cmd_mode(trig_cmd_mode),
   .temp_ok(temp_ok), .pixel_count(pixel_count), .trig_mode_q(trig_mode_q));
